// ==== logic/uaf_defines.svh ====
`ifndef UAF_DEFINES_SVH
`define UAF_DEFINES_SVH

// register offsets on the 8-bit register port
`define UAF_OFS_PWR       8'h87
`define UAF_OFS_CTL       8'h98
`define UAF_OFS_BUF       8'h99
`define UAF_OFS_OWN_ADR   8'hA9
`define UAF_OFS_OWN_MSK   8'hB9
`define UAF_OFS_BSRC      8'hCA

// serial control register fields
`define UAF_CTL_MODE_A    7
`define UAF_CTL_MODE_B    6
`define UAF_CTL_FILT      5
`define UAF_CTL_REN       4
`define UAF_CTL_TX9       3
`define UAF_CTL_RX9       2
`define UAF_CTL_TXDONE    1
`define UAF_CTL_RXDONE    0

// power control register fields
`define UAF_PWR_DBL       7
`define UAF_PWR_EVS       6

// baud source register fields
`define UAF_BSRC_TX_T2    0
`define UAF_BSRC_RX_T2    1

// reset values
`define UAF_OWN_ADR_RST   8'h00
`define UAF_OWN_MSK_RST   8'h00

// rates
`define UAF_M0_DIV        12
`define UAF_M2_TICK_DIV   4
`define UAF_OVS           16
`define UAF_SAMPLE_PT     7

`endif

// ==== logic/uaf_pkg.sv ====
package uaf_pkg;

    typedef enum logic [1:0] {
        UAF_MODE_SHIFT,
        UAF_MODE_UART8,
        UAF_MODE_UART9F,
        UAF_MODE_UART9V
    } uaf_mode_t;

    typedef enum logic [1:0] {
        UAF_TX_IDLE,
        UAF_TX_SHIFT,
        UAF_TX_ASYNC
    } uaf_tx_st_t;

    typedef enum logic [1:0] {
        UAF_RX_IDLE,
        UAF_RX_SHIFT,
        UAF_RX_ASYNC
    } uaf_rx_st_t;

    typedef struct packed {
        logic tx16;
        logic rx16;
        logic m0_bit;
        logic m0_mid;
        logic m0_low;
    } uaf_ticks_t;

    typedef struct packed {
        uaf_mode_t mode;
        logic      baud_double;
        logic      tx_use_t2;
        logic      rx_use_t2;
    } uaf_baud_cfg_t;

endpackage

// ==== logic/uaf_baud_gen.sv ====
`include "uaf_defines.svh"

module uaf_baud_gen #(
    parameter int M0_DIV = `UAF_M0_DIV,
    parameter int M2_DIV = `UAF_M2_TICK_DIV
) (
    input  wire logic                   ref_clk,
    input  wire logic                   resetn,
    input  wire logic                   ce,
    input  wire uaf_pkg::uaf_baud_cfg_t cfg,
    input  wire logic                   t1_ovf,
    input  wire logic                   t2_ovf,
    output uaf_pkg::uaf_ticks_t         ticks
);
    localparam int M0_HALF = M0_DIV / 2;

    logic [3:0] m0_cnt_q;
    logic [3:0] m2_cnt_q;
    logic       t1_half_q;
    logic [3:0] m2_last;
    logic       m2_tick;
    logic       t1_tick;

    function automatic logic pick(input logic use_t2, input uaf_pkg::uaf_mode_t m,
                                  input logic m2, input logic t1, input logic t2);
        if (m == uaf_pkg::UAF_MODE_UART9F)
            return m2;
        return use_t2 ? t2 : t1;
    endfunction

    // 16 sample ticks per bit: /4 gives osc/64, /2 gives osc/32
    assign m2_last = cfg.baud_double ? 4'(M2_DIV / 2 - 1) : 4'(M2_DIV - 1); // RULE_13
    assign m2_tick = m2_cnt_q >= m2_last;
    // overflow/32 is every second overflow per tick, doubling takes every one
    assign t1_tick = t1_ovf & (cfg.baud_double | t1_half_q); // RULE_15

    always_ff @(posedge ref_clk) begin
        if (!resetn)
            m0_cnt_q <= 4'h0;
        else if (ce)
            m0_cnt_q <= (m0_cnt_q == 4'(M0_DIV - 1)) ? 4'h0 : m0_cnt_q + 4'h1; // RULE_12
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn)
            m2_cnt_q <= 4'h0;
        else if (ce)
            m2_cnt_q <= m2_tick ? 4'h0 : m2_cnt_q + 4'h1;
    end

    // only the overflow pulse is used, so any timer running mode serves
    always_ff @(posedge ref_clk) begin
        if (!resetn)
            t1_half_q <= 1'b0;
        else if (ce && t1_ovf)
            t1_half_q <= ~t1_half_q; // RULE_16
    end

    assign ticks.tx16   = ce & pick(cfg.tx_use_t2, cfg.mode, m2_tick, t1_tick, t2_ovf); // RULE_14
    assign ticks.rx16   = ce & pick(cfg.rx_use_t2, cfg.mode, m2_tick, t1_tick, t2_ovf); // RULE_14
    assign ticks.m0_bit = ce & (m0_cnt_q == 4'(M0_DIV - 1)); // RULE_12
    assign ticks.m0_mid = ce & (m0_cnt_q == 4'(M0_HALF - 1));
    assign ticks.m0_low = m0_cnt_q < 4'(M0_HALF);

endmodule // uaf_baud_gen

// ==== logic/uaf_addr_match.sv ====
module uaf_addr_match (
    input  wire logic [7:0] rx_byte,
    input  wire logic [7:0] own_adr,
    input  wire logic [7:0] own_msk,
    output logic            given_hit,
    output logic            bcast_hit
);
    logic [7:0] bcast;

    assign bcast     = own_adr | own_msk; // RULE_10
    assign given_hit = ((rx_byte ^ own_adr) & own_msk) == 8'h00; // RULE_09
    assign bcast_hit = ((rx_byte ^ bcast) & bcast) == 8'h00; // RULE_10

endmodule // uaf_addr_match

// ==== logic/uaf_core.sv ====
// Operation
// RULE_01 - modes 1-3: sample stop bit, set framing error flag if it is zero
// RULE_02 - framing error flag sticks until software clears it; valid stops never clear
// RULE_03 - control bit 7 reaches mode bit, or error flag when error view select is 1
// RULE_04 - modes 2/3 store received ninth bit; transmitter sends software ninth bit
// RULE_05 - ninth bit 1 marks address bytes, 0 marks data bytes
// RULE_06 - 9-bit modes with filtering: done only on ninth bit 1 and address match
// RULE_07 - mode 1 with filtering: done only on address match and valid stop bit
// RULE_08 - filter enable has no effect in mode 0
// RULE_09 - given match compares only where mask bit is 1
// RULE_10 - broadcast address is address OR mask; its zero bits are don't-care
// RULE_11 - address and mask reset to zero so every byte matches
// RULE_12 - mode 0 shifts at oscillator over 12, fixed
// RULE_13 - mode 2 bit rate is oscillator over 64, or over 32 when doubled
// RULE_14 - modes 1/3 rate from timer 1 or timer 2 overflows, per direction
// RULE_15 - timer 1 source: overflow rate over 32, doubled by baud double bit
// RULE_16 - timer 1 works as source in any running mode
// RULE_17 - software keeps timer 1 interrupt off while it is the rate source
// RULE_18 - mode bits 00/01/10/11 select modes 0/1/2/3
// RULE_19 - async reception starts on start bit with enable; mode 0 needs done flag 0
// RULE_20 - 9-bit frames: start 0, eight data bits lsb first, ninth bit, stop 1
`include "uaf_defines.svh"

module uaf_core #(
    parameter int OVS = `UAF_OVS
) (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       t1_ovf,
    input  wire logic       t2_ovf,
    input  wire logic       rxd_in,
    output logic            rxd_out,
    output logic            rxd_oe,
    output logic            txd
);
    localparam logic [3:0] SUB_LAST = 4'(OVS - 1);
    localparam logic [3:0] SUB_SAMP = 4'(`UAF_SAMPLE_PT);

    // control and configuration
    logic                   mode_a_q;
    logic                   mode_b_q;
    logic                   filt_q;
    logic                   ren_q;
    logic                   tx9_q;
    logic                   rx9_q;
    logic                   txdone_q;
    logic                   rxdone_q;
    logic                   ferr_q;
    logic                   dbl_q;
    logic                   evs_q;
    logic                   tx_t2_q;
    logic                   rx_t2_q;
    logic [7:0]             own_adr_q;
    logic [7:0]             own_msk_q;
    logic [7:0]             rxbuf_q;
    logic [7:0]             rdata_q;
    uaf_pkg::uaf_mode_t     mode;
    uaf_pkg::uaf_baud_cfg_t cfg;
    uaf_pkg::uaf_ticks_t    ticks;
    logic                   nine;
    logic                   wr_ctl;
    logic                   wr_buf;

    // transmitter
    uaf_pkg::uaf_tx_st_t    tx_st_q;
    logic [10:0]            tx_sh_q;
    logic [3:0]             tx_cnt_q;
    logic [3:0]             tx_sub_q;
    logic                   tx_finish;

    // receiver
    uaf_pkg::uaf_rx_st_t    rx_st_q;
    logic                   rx_meta_q;
    logic                   rx_sync_q;
    logic                   rx_prev_q;
    logic [7:0]             rx_sh_q;
    logic                   rx_nb_q;
    logic [3:0]             rx_cnt_q;
    logic [3:0]             rx_sub_q;
    logic                   rx_samp;
    logic                   rx_stop;
    logic                   rx_m0_done;
    logic                   ninth_v;
    logic                   given_hit;
    logic                   bcast_hit;
    logic                   rx_accept;
    logic                   rx_load;
    logic                   rx_ferr;

    // pins
    logic                   m0_active;
    logic                   txd_q;
    logic                   rxd_out_q;
    logic                   rxd_oe_q;

    assign mode   = uaf_pkg::uaf_mode_t'({mode_a_q, mode_b_q}); // RULE_18
    assign nine   = mode == uaf_pkg::UAF_MODE_UART9F || mode == uaf_pkg::UAF_MODE_UART9V;
    assign wr_ctl = reg_wr && reg_addr == `UAF_OFS_CTL;
    assign wr_buf = reg_wr && reg_addr == `UAF_OFS_BUF;

    assign cfg.mode        = mode;
    assign cfg.baud_double = dbl_q;
    assign cfg.tx_use_t2   = tx_t2_q;
    assign cfg.rx_use_t2   = rx_t2_q;

    uaf_baud_gen u_baud (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .ce      (ce),
        .cfg     (cfg),
        .t1_ovf  (t1_ovf),
        .t2_ovf  (t2_ovf),
        .ticks   (ticks)
    );

    uaf_addr_match u_match (
        .rx_byte   (rx_sh_q),
        .own_adr   (own_adr_q),
        .own_msk   (own_msk_q),
        .given_hit (given_hit),
        .bcast_hit (bcast_hit)
    );

    // software-owned control bits
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            mode_a_q <= 1'b0;
            mode_b_q <= 1'b0;
            filt_q   <= 1'b0;
            ren_q    <= 1'b0;
            tx9_q    <= 1'b0;
        end else if (ce && wr_ctl) begin
            if (!evs_q)
                mode_a_q <= reg_wdata[`UAF_CTL_MODE_A]; // RULE_03
            mode_b_q <= reg_wdata[`UAF_CTL_MODE_B];
            filt_q   <= reg_wdata[`UAF_CTL_FILT];
            ren_q    <= reg_wdata[`UAF_CTL_REN];
            tx9_q    <= reg_wdata[`UAF_CTL_TX9];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            dbl_q   <= 1'b0;
            evs_q   <= 1'b0;
            tx_t2_q <= 1'b0;
            rx_t2_q <= 1'b0;
            own_adr_q <= `UAF_OWN_ADR_RST; // RULE_11
            own_msk_q <= `UAF_OWN_MSK_RST; // RULE_11
        end else if (ce && reg_wr) begin
            case (reg_addr)
                `UAF_OFS_PWR: begin
                    dbl_q <= reg_wdata[`UAF_PWR_DBL];
                    evs_q <= reg_wdata[`UAF_PWR_EVS];
                end
                `UAF_OFS_BSRC: begin
                    tx_t2_q <= reg_wdata[`UAF_BSRC_TX_T2];
                    rx_t2_q <= reg_wdata[`UAF_BSRC_RX_T2];
                end
                `UAF_OFS_OWN_ADR: own_adr_q <= reg_wdata;
                `UAF_OFS_OWN_MSK: own_msk_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // hardware-set flags: a set in the same cycle as a software write wins
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            txdone_q <= 1'b0;
            rxdone_q <= 1'b0;
            rx9_q    <= 1'b0;
            ferr_q   <= 1'b0;
            rxbuf_q  <= 8'h00;
        end else if (ce) begin
            if (tx_finish)
                txdone_q <= 1'b1;
            else if (wr_ctl)
                txdone_q <= reg_wdata[`UAF_CTL_TXDONE];
            if (rx_load)
                rxdone_q <= 1'b1;
            else if (wr_ctl)
                rxdone_q <= reg_wdata[`UAF_CTL_RXDONE];
            if (rx_load && mode != uaf_pkg::UAF_MODE_SHIFT)
                rx9_q <= ninth_v; // RULE_04
            else if (wr_ctl)
                rx9_q <= reg_wdata[`UAF_CTL_RX9];
            if (rx_ferr)
                ferr_q <= 1'b1; // RULE_01
            else if (wr_ctl && evs_q)
                ferr_q <= reg_wdata[`UAF_CTL_MODE_A]; // RULE_02 RULE_03
            if (rx_load)
                rxbuf_q <= rx_sh_q;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!resetn)
            rdata_q <= 8'h00;
        else if (ce) begin
            rdata_q <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    `UAF_OFS_CTL: rdata_q <= {evs_q ? ferr_q : mode_a_q, mode_b_q, filt_q, // RULE_03
                                              ren_q, tx9_q, rx9_q, txdone_q, rxdone_q};
                    `UAF_OFS_BUF:   rdata_q <= rxbuf_q;
                    `UAF_OFS_PWR:   rdata_q <= {dbl_q, evs_q, 6'h00};
                    `UAF_OFS_BSRC:  rdata_q <= {6'h00, rx_t2_q, tx_t2_q};
                    `UAF_OFS_OWN_ADR: rdata_q <= own_adr_q;
                    `UAF_OFS_OWN_MSK: rdata_q <= own_msk_q;
                    default:        rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign reg_rdata = rdata_q;

    // transmitter; a write while busy is dropped
    assign tx_finish = ce && ((tx_st_q == uaf_pkg::UAF_TX_SHIFT && ticks.m0_bit && tx_cnt_q == 4'h1)
                     || (tx_st_q == uaf_pkg::UAF_TX_ASYNC && ticks.tx16
                         && tx_sub_q == SUB_LAST && tx_cnt_q == 4'h1));

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            tx_st_q  <= uaf_pkg::UAF_TX_IDLE;
            tx_sh_q  <= 11'h7FF;
            tx_cnt_q <= 4'h0;
            tx_sub_q <= 4'h0;
        end else if (ce) begin
            case (tx_st_q)
                uaf_pkg::UAF_TX_IDLE: begin
                    if (wr_buf && mode == uaf_pkg::UAF_MODE_SHIFT) begin
                        // leading idle slot aligns the first bit to a full shift period
                        tx_st_q  <= uaf_pkg::UAF_TX_SHIFT;
                        tx_sh_q  <= {2'b11, reg_wdata, 1'b1};
                        tx_cnt_q <= 4'h9;
                    end else if (wr_buf) begin
                        tx_st_q  <= uaf_pkg::UAF_TX_ASYNC;
                        tx_sh_q  <= {1'b1, nine ? tx9_q : 1'b1, reg_wdata, 1'b0}; // RULE_04 RULE_05 RULE_20
                        tx_cnt_q <= nine ? 4'hB : 4'hA;
                        tx_sub_q <= 4'h0;
                    end
                end
                uaf_pkg::UAF_TX_SHIFT: begin
                    if (ticks.m0_bit) begin
                        tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
                        tx_cnt_q <= tx_cnt_q - 4'h1;
                        if (tx_cnt_q == 4'h1)
                            tx_st_q <= uaf_pkg::UAF_TX_IDLE;
                    end
                end
                uaf_pkg::UAF_TX_ASYNC: begin
                    if (ticks.tx16) begin
                        tx_sub_q <= tx_sub_q + 4'h1;
                        if (tx_sub_q == SUB_LAST) begin
                            tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
                            tx_cnt_q <= tx_cnt_q - 4'h1;
                            if (tx_cnt_q == 4'h1)
                                tx_st_q <= uaf_pkg::UAF_TX_IDLE;
                        end
                    end
                end
                default: tx_st_q <= uaf_pkg::UAF_TX_IDLE;
            endcase
        end
    end

    // receive pin synchroniser and edge history
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else if (ce) begin
            rx_meta_q <= rxd_in;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end

    // async sample point; rx_cnt_q is the frame position, 0 = start bit
    assign rx_samp    = rx_st_q == uaf_pkg::UAF_RX_ASYNC && ticks.rx16 && rx_sub_q == SUB_SAMP;
    assign rx_stop    = rx_samp && rx_cnt_q == (nine ? 4'hA : 4'h9);
    assign rx_m0_done = rx_st_q == uaf_pkg::UAF_RX_SHIFT && ticks.m0_bit && rx_cnt_q == 4'h1;
    // in mode 1 the stop bit stands in the ninth bit's place
    assign ninth_v    = nine ? rx_nb_q : rx_sync_q;
    assign rx_accept  = !rxdone_q && (!filt_q || (ninth_v && (given_hit || bcast_hit))); // RULE_05 RULE_06 RULE_07
    assign rx_load    = ce && (rx_m0_done || (rx_stop && rx_accept)); // RULE_08
    assign rx_ferr    = ce && rx_stop && !rx_sync_q; // RULE_01

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rx_st_q  <= uaf_pkg::UAF_RX_IDLE;
            rx_sh_q  <= 8'h00;
            rx_nb_q  <= 1'b0;
            rx_cnt_q <= 4'h0;
            rx_sub_q <= 4'h0;
        end else if (ce) begin
            case (rx_st_q)
                uaf_pkg::UAF_RX_IDLE: begin
                    if (mode == uaf_pkg::UAF_MODE_SHIFT && ren_q && !rxdone_q
                        && tx_st_q == uaf_pkg::UAF_TX_IDLE) begin // RULE_19
                        rx_st_q  <= uaf_pkg::UAF_RX_SHIFT;
                        rx_cnt_q <= 4'h9;
                    end else if (mode != uaf_pkg::UAF_MODE_SHIFT && ren_q
                                 && rx_prev_q && !rx_sync_q) begin // RULE_19
                        rx_st_q  <= uaf_pkg::UAF_RX_ASYNC;
                        rx_cnt_q <= 4'h0;
                        rx_sub_q <= 4'h0;
                    end
                end
                uaf_pkg::UAF_RX_SHIFT: begin
                    if (ticks.m0_mid && rx_cnt_q <= 4'h8)
                        rx_sh_q <= {rx_sync_q, rx_sh_q[7:1]};
                    if (ticks.m0_bit) begin
                        rx_cnt_q <= rx_cnt_q - 4'h1;
                        if (rx_cnt_q == 4'h1)
                            rx_st_q <= uaf_pkg::UAF_RX_IDLE;
                    end
                end
                uaf_pkg::UAF_RX_ASYNC: begin
                    if (ticks.rx16)
                        rx_sub_q <= rx_sub_q + 4'h1;
                    if (ticks.rx16 && rx_sub_q == SUB_LAST)
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                    if (rx_samp) begin
                        // start bit high at mid-bit was a glitch: back to hunting
                        if (rx_cnt_q == 4'h0 && rx_sync_q)
                            rx_st_q <= uaf_pkg::UAF_RX_IDLE;
                        else if (rx_cnt_q >= 4'h1 && rx_cnt_q <= 4'h8)
                            rx_sh_q <= {rx_sync_q, rx_sh_q[7:1]}; // RULE_20
                        else if (rx_cnt_q == 4'h9 && nine)
                            rx_nb_q <= rx_sync_q; // RULE_04
                        if (rx_stop)
                            rx_st_q <= uaf_pkg::UAF_RX_IDLE;
                    end
                end
                default: rx_st_q <= uaf_pkg::UAF_RX_IDLE;
            endcase
        end
    end

    // pins are registered; mode 0 puts the shift clock on txd
    assign m0_active = (tx_st_q == uaf_pkg::UAF_TX_SHIFT && tx_cnt_q <= 4'h8)
                    || (rx_st_q == uaf_pkg::UAF_RX_SHIFT && rx_cnt_q <= 4'h8);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            txd_q     <= 1'b1;
            rxd_out_q <= 1'b1;
            rxd_oe_q  <= 1'b0;
        end else if (ce) begin
            if (mode == uaf_pkg::UAF_MODE_SHIFT)
                txd_q <= m0_active ? ~ticks.m0_low : 1'b1;
            else
                txd_q <= tx_st_q == uaf_pkg::UAF_TX_ASYNC ? tx_sh_q[0] : 1'b1;
            rxd_out_q <= tx_sh_q[0];
            rxd_oe_q  <= tx_st_q == uaf_pkg::UAF_TX_SHIFT && tx_cnt_q <= 4'h8;
        end
    end

    assign txd     = txd_q;
    assign rxd_out = rxd_out_q;
    assign rxd_oe  = rxd_oe_q;

endmodule // uaf_core

// ==== bench/uaf_core_sva.sv ====
module uaf_core_sva (
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic       ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       rxd_oe,
    input wire logic       txd
);
    logic [7:0] sa_q, sm_q;
    logic       ma_q, mb_q, t9_q, dbl_q, evs_q;
    logic       rd_c, rd_s, rd_m, rd_p;
    assign rd_c = ce && reg_rd && reg_addr == 8'h98;
    assign rd_s = ce && reg_rd && reg_addr == 8'hA9;
    assign rd_m = ce && reg_rd && reg_addr == 8'hB9;
    assign rd_p = ce && reg_rd && reg_addr == 8'h87;
    // shadow of software-owned bits, flags left out
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            {sa_q, sm_q, ma_q, mb_q, t9_q, dbl_q, evs_q} <= '0;
        end else if (ce && reg_wr) begin
            if (reg_addr == 8'hA9) sa_q <= reg_wdata;
            if (reg_addr == 8'hB9) sm_q <= reg_wdata;
            if (reg_addr == 8'h87) {dbl_q, evs_q} <= reg_wdata[7:6];
            if (reg_addr == 8'h98) {mb_q, t9_q} <= {reg_wdata[6], reg_wdata[3]};
            if (reg_addr == 8'h98 && !evs_q) ma_q <= reg_wdata[7];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    AST_OWN_ADR_RD: assert property (rd_s |=> reg_rdata == $past(sa_q))
        else $error("slave address readback wrong");
    AST_OWN_MSK_RD: assert property (rd_m |=> reg_rdata == $past(sm_q))
        else $error("address mask readback wrong");
    AST_MODE_A_VIEW: assert property (rd_c && !evs_q |=> reg_rdata[7] == $past(ma_q))
        else $error("bit 7 does not show mode bit");
    AST_MODE_B_RD: assert property (rd_c |=> reg_rdata[6] == $past(mb_q))
        else $error("mode bit b readback wrong");
    AST_TX9_RD: assert property (rd_c |=> reg_rdata[3] == $past(t9_q))
        else $error("tx ninth bit readback wrong");
    AST_PWR_RD: assert property (rd_p |=> reg_rdata == {$past(dbl_q), $past(evs_q), 6'h00})
        else $error("power control readback wrong");
    AST_NO_OE_ASYNC: assert property ({ma_q, mb_q} != 2'b00 |-> !rxd_oe)
        else $error("rxd driven in async mode");
    // shortest legal bit is 16 clocks
    AST_START_LEN: assert property ($fell(txd) && {ma_q, mb_q} != 2'b00 |-> !txd [*8])
        else $error("start bit too short");
    COV_TX: cover property ($fell(txd));
    COV_FE_VIEW: cover property (rd_c && evs_q);
    COV_ADDR_RD: cover property (rd_s);
endmodule // uaf_core_sva

// ==== bench/uaf_peer.sv ====
module uaf_peer #(
    parameter int BIT = 32
) (
    input  wire logic ref_clk,
    input  wire logic txd,
    output logic      rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    // pulled-up line idles high
    initial rxd = 1'b1;
    task automatic send(input logic [8:0] d, input logic stop);
        logic [10:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (BIT) @(posedge ref_clk);
        end
        rxd <= 1'b1;
        repeat (BIT) @(posedge ref_clk);
    endtask
    // samples mid-bit, so a wrong rate corrupts data
    task automatic capture(output logic [8:0] d, output logic ok);
        int n;
        n = 0;
        while (txd !== 1'b0 && n < 2000) begin
            @(posedge ref_clk);
            n++;
        end
        repeat (BIT / 2) @(posedge ref_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge ref_clk);
            d[i] = txd;
        end
        repeat (BIT) @(posedge ref_clk);
        ok = (n < 2000) && (txd === 1'b1);
    endtask
endmodule // uaf_peer

// ==== bench/uaf_core_test.sv ====
module uaf_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk = 1'b0;
    logic       resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       tov = 1'b0;
    logic       ce = 1'b1;
    logic [7:0] reg_rdata, v, e;
    logic       rxd_in, prx, rxd_out, rxd_oe, txd, ok;
    logic [8:0] d;
    logic [9:0] fr [4] = '{10'h3F0, 10'h0F0, 10'h100, 10'h3FF};
    int         n_fail = 0;
    int         compares = 0;
    always #25 ref_clk = ~ref_clk;
    // overflow pulse every second clock on both timers
    always @(posedge ref_clk) tov <= ~tov;
    assign rxd_in = rxd_oe ? rxd_out : prx;
    uaf_core u_uaf_core (
        .ref_clk(ref_clk), .resetn(resetn), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .t1_ovf(tov), .t2_ovf(tov),
        .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
    uaf_peer u_uaf_peer (.ref_clk(ref_clk), .txd(txd), .rxd(prx));
    task automatic complete_run();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [9:0] g, input logic [9:0] x);
        compares++;
        if (g !== x) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 r = reg_rdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] x);
        logic [7:0] r;
        rd(a, r);
        chk(r, x);
    endtask
    task automatic wait_set(input logic [7:0] m);
        for (int i = 0; i < 200; i++) begin
            rd(8'h98, v);
            if ((v & m) !== 8'h00) return;
        end
        n_fail++;
        complete_run();
    endtask
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_fail++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rchk(8'hA9, 8'h00);
        rchk(8'hB9, 8'h00);
        rchk(8'h87, 8'h00);
        rchk(8'h55, 8'h00);
        wr(8'hA9, 8'hF1);
        wr(8'hB9, 8'hFA);
        rchk(8'hA9, 8'hF1);
        rchk(8'hB9, 8'hFA);
        // a write while the clock enable is low must not land
        ce <= 1'b0;
        wr(8'hA9, 8'h12);
        ce <= 1'b1;
        rchk(8'hA9, 8'hF1);
        $display("test registers done");
        wr(8'h87, 8'h80);
        wr(8'h98, 8'h88);
        fork
            u_uaf_peer.capture(d, ok);
            wr(8'h99, 8'hA5);
        join
        chk({ok, d}, 10'h3A5);
        wait_set(8'h02);
        wr(8'h98, 8'hC0);
        fork
            u_uaf_peer.capture(d, ok);
            wr(8'h99, 8'h3C);
        join
        chk({ok, d}, 10'h23C);
        wait_set(8'h02);
        $display("test transmit done");
        // receive on timer 2 while timer 1 path would run at half rate
        wr(8'h87, 8'h00);
        wr(8'hCA, 8'h02);
        wr(8'h98, 8'hF0);
        for (int i = 0; i < 4; i++) begin
            u_uaf_peer.send(fr[i][8:0], 1'b1);
            rd(8'h98, v);
            e = fr[i][9] ? 8'h05 : 8'h00;
            chk(v & (e | 8'h01), e);
            if (fr[i][9]) rchk(8'h99, fr[i][7:0]);
            wr(8'h98, 8'hF0);
        end
        $display("test filter done");
        wr(8'h87, 8'h40);
        wr(8'h98, 8'h50);
        u_uaf_peer.send(9'h055, 1'b0);
        rd(8'h98, v);
        chk(v & 8'h81, 8'h81);
        wr(8'h98, 8'hD0);
        u_uaf_peer.send(9'h155, 1'b1);
        rd(8'h98, v);
        chk(v & 8'h81, 8'h81);
        wr(8'h98, 8'h50);
        rchk(8'h98, 8'h50);
        wr(8'h87, 8'h00);
        rchk(8'h98, 8'hD0);
        wr(8'h98, 8'hC0);
        u_uaf_peer.send(9'h1AA, 1'b1);
        rchk(8'h98, 8'hC0);
        // mode 1: the peer's ninth bit sits in the stop slot
        wr(8'h98, 8'h70);
        u_uaf_peer.send(9'h0F0, 1'b1);
        rchk(8'h98, 8'h70);
        u_uaf_peer.send(9'h1F0, 1'b1);
        rchk(8'h98, 8'h75);
        // mode 0 takes a byte that the filter would refuse
        fork
            u_uaf_peer.send(9'h000, 1'b0);
            wr(8'h98, 8'h30);
        join
        rchk(8'h98, 8'h31);
        rchk(8'h99, 8'h00);
        $display("test framing done");
        complete_run();
    end
endmodule // uaf_core_test

bind uaf_core uaf_core_sva u_uaf_core_sva (
    .ref_clk(ref_clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rxd_oe(rxd_oe), .txd(txd));
